// ---- dcs_arb.sv ----
/*
  Arbiter picking one row command among valid entries and one column command among ready ones.
  Assumes the global timer gates activates through act_ok.
*/
`timescale 1ns/1ns
module dcs_arb
  import dcs_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic act_ok,
  input  wire logic hold,
  input  wire logic quasi,
  dcs_tbp_if.arb    tbp
);
  logic [TAG_W-1:0] rr;

  // Lower score wins: starved, then priority, then round-robin order
  function automatic logic [1:0] rank(input logic old, input logic pri);
    return old ? 2'h0 : (pri ? 2'h1 : 2'h2);
  endfunction

  always_comb begin
    logic [1:0]       best_c;
    logic [1:0]       best_r;
    logic [TAG_W-1:0] k;
    best_c = 2'h3;
    best_r = 2'h3;
    k = '0;
    tbp.issue_col = 1'b0;
    tbp.issue_row = 1'b0;
    tbp.col_idx   = '0;
    tbp.row_idx   = '0;
    for (int i = 0; i < POOL_DEPTH; i++) begin
      k = rr + TAG_W'(i);
      if (!hold && tbp.ready[k] && tbp.row_open[k] &&
          rank(tbp.age_old[k], tbp.req[k].prio) < best_c) begin
        best_c = rank(tbp.age_old[k], tbp.req[k].prio);
        tbp.issue_col = 1'b1;
        tbp.col_idx   = k;
      end
      if (!hold && act_ok && tbp.valid[k] && !tbp.row_open[k] &&
          rank(tbp.age_old[k], tbp.req[k].prio) < best_r) begin
        best_r = rank(tbp.age_old[k], tbp.req[k].prio);
        tbp.issue_row = 1'b1;
        tbp.row_idx   = k;
      end
    end
    // Quasi modes pair a row with a column in one cycle; otherwise one per
    // cycle, column first. A row still goes alone when no column is ready,
    // since columns wait on open rows and the pool would never drain.
    if (!quasi && tbp.issue_col)
      tbp.issue_row = 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      rr <= '0;
    else if (ce && tbp.issue_col)
      rr <= tbp.col_idx + TAG_W'(1);
  end
endmodule

// ---- dcs_chk_properties.sv ----
/*
  Concurrent checks on the scheduler's top-level ports.
  Assumes ce stays high while commands are in flight.
*/
`timescale 1ns/1ns
module dcs_chk
  import dcs_pkg::*;
#(
  parameter int BUF_AW = 4
) (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              ce,
  input wire logic [CFG_W-1:0]  cfg_wdata,
  input wire logic              cfg_we,
  input wire logic [CFG_W-1:0]  cfg_rdata,
  input wire logic              usr_ready,
  input wire logic              usr_stall,
  input wire logic              usr_wdata_valid,
  input wire logic [BUF_AW-1:0] wbuf_fill_ptr,
  input wire logic [BUF_AW-1:0] rbuf_fill_ptr,
  input wire logic              phy_rdata_valid,
  input wire logic [2:0]        phy_cmd,
  input wire logic              phy_wdata_valid,
  input wire logic              phy_cke
);
  // Activates of the last seven cycles; with the current one spans the window
  logic [6:0] act_hist;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_hist <= '0;
    end else begin
      act_hist <= {act_hist[5:0], phy_cmd == DCS_CMD_ACT};
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  reset_outputs_a: assert property ($fell(rst) |-> phy_cmd == 3'h0 && phy_cke)
    else $error("command port not idle out of reset");
  reset_flow_a: assert property ($fell(rst) |-> !usr_stall && usr_ready && wbuf_fill_ptr == 0)
    else $error("flow control or pointer not cleared by reset");
  stall_blocks_a: assert property (usr_stall |-> !usr_ready)
    else $error("ready while pool full");
  act_spacing_a: assert property (phy_cmd == DCS_CMD_ACT |=> phy_cmd != DCS_CMD_ACT)
    else $error("activates too close");
  act_window_a: assert property ($countones({act_hist, phy_cmd == DCS_CMD_ACT}) <= 4)
    else $error("more than four activates in window");
  write_latency_a: assert property (phy_cmd == DCS_CMD_WR |-> ##2 phy_wdata_valid)
    else $error("write data late or missing");
  wdata_cause_a: assert property (phy_wdata_valid |-> $past(phy_cmd, 2) == DCS_CMD_WR)
    else $error("write data without write command");
  cfg_readback_a: assert property (ce && cfg_we |=> cfg_rdata == $past(cfg_wdata))
    else $error("config readback differs");
  wfill_step_a: assert property (ce && usr_wdata_valid |=> wbuf_fill_ptr == $past(wbuf_fill_ptr) + 1'b1)
    else $error("write fill pointer did not step");
  rfill_step_a: assert property (ce && phy_rdata_valid |=> rbuf_fill_ptr == $past(rbuf_fill_ptr) + 1'b1)
    else $error("read fill pointer did not step");
endmodule

bind dcs_top dcs_chk #(.BUF_AW(BUF_AW)) i_chk (.clk_sys, .rst, .ce, .cfg_wdata, .cfg_we,
  .cfg_rdata, .usr_ready, .usr_stall, .usr_wdata_valid, .wbuf_fill_ptr, .rbuf_fill_ptr,
  .phy_rdata_valid, .phy_cmd, .phy_wdata_valid, .phy_cke);

// ---- dcs_pkg.sv ----
/*
  Shared constants and types of the DDR command scheduler.
  Assumes a single controller clock of 20 MHz.
*/
package dcs_pkg;
  localparam int POOL_DEPTH       = 8;
  localparam int ADDR_W           = 28;
  localparam int BANK_W           = 3;
  localparam int LEN_W            = 7;
  localparam int MAX_BURST        = 127;
  localparam int MM_MAX_BURST     = 64;
  localparam int TAG_W            = 3;
  localparam int ACT_WINDOW_COUNT = 4;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int FAW_NS           = 400;
  localparam int RRD_NS           = 100;
  localparam int FAW_CYC          = (FAW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RRD_CYC          = (RRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARVE_CYC       = 64;
  localparam int REFRESH_CYC      = 156;
  localparam int IDLE_PD_CYC      = 32;
  localparam int WRITE_LAT_CYC    = 2;
  localparam logic [1:0] BL_DDR3  = 2'h2;
  localparam logic [1:0] BL_LP3   = 2'h2;
  localparam int CFG_W            = 8;
  localparam int CFG_MM_BIT       = 0;
  localparam int CFG_QRATE_BIT    = 1;
  localparam int CFG_QUASI_BIT    = 2;
  localparam int CFG_LPDDR3_BIT   = 3;
  localparam int CFG_PD_EN_BIT    = 4;

  typedef enum logic [2:0] {
    DCS_CMD_NOP, DCS_CMD_ACT, DCS_CMD_PRE, DCS_CMD_RD, DCS_CMD_WR,
    DCS_CMD_REF, DCS_CMD_PDE, DCS_CMD_PDX
  } dcs_cmd_e;

  typedef struct packed {
    logic              is_wr;
    logic              rmw;
    logic              prio;
    logic [ADDR_W-1:0] addr;
  } dcs_req_s;
endpackage

// ---- dcs_pool.sv ----
/*
  Eight-entry scoreboard tracking outstanding commands and hazards.
  Assumes one allocation per cycle and the arbiter's issue strobes.
*/
`timescale 1ns/1ns
module dcs_pool
  import dcs_pkg::*;
(
  input  wire logic     clk_sys,
  input  wire logic     rst,
  input  wire logic     ce,
  input  wire logic     alloc,
  input  wire dcs_req_s alloc_req,
  output logic          full,
  dcs_tbp_if.pool       tbp
);
  logic                  vld   [POOL_DEPTH];
  logic                  opn   [POOL_DEPTH];
  logic [7:0]            age   [POOL_DEPTH];
  logic [POOL_DEPTH-1:0] older [POOL_DEPTH];
  logic [TAG_W-1:0]      free_idx;
  logic                  any_free;

  always_comb begin
    any_free = 1'b0;
    free_idx = '0;
    for (int i = POOL_DEPTH - 1; i >= 0; i--) begin
      if (!vld[i]) begin
        any_free = 1'b1;
        free_idx = TAG_W'(i);
      end
    end
  end
  assign full = !any_free;

  genvar g;
  generate
    for (g = 0; g < POOL_DEPTH; g++) begin : g_ent
      logic hazard;
      always_comb begin
        hazard = 1'b0;
        for (int j = 0; j < POOL_DEPTH; j++) begin
          // Same location, older, and at least one a write
          if (vld[j] && older[g][j] && tbp.req[j].addr == tbp.req[g].addr &&
              (tbp.req[j].is_wr || tbp.req[g].is_wr))
            hazard = 1'b1;
        end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          vld[g]   <= 1'b0;
          opn[g]   <= 1'b0;
          age[g]   <= 8'h00;
          older[g] <= '0;
        end else if (ce) begin
          if (alloc && any_free && free_idx == TAG_W'(g)) begin
            vld[g] <= 1'b1;
            opn[g] <= 1'b0;
            age[g] <= 8'h00;
            for (int j = 0; j < POOL_DEPTH; j++)
              older[g][j] <= vld[j];
          end else if (vld[g]) begin
            if (age[g] != 8'hff)
              age[g] <= age[g] + 8'h01;
            if (tbp.issue_row && tbp.row_idx == TAG_W'(g))
              opn[g] <= 1'b1;
            if (tbp.issue_col && tbp.col_idx == TAG_W'(g))
              vld[g] <= 1'b0;
          end
          for (int j = 0; j < POOL_DEPTH; j++)
            if (tbp.issue_col && tbp.col_idx == TAG_W'(j))
              older[g][j] <= 1'b0;
        end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
          tbp.req[g] <= '0;
        else if (ce && alloc && any_free && free_idx == TAG_W'(g))
          tbp.req[g] <= alloc_req;
      end
      assign tbp.valid[g]    = vld[g];
      assign tbp.row_open[g] = opn[g];
      assign tbp.ready[g]    = vld[g] && !hazard;
      assign tbp.age_old[g]  = age[g] >= 8'(STARVE_CYC);
    end
  endgenerate
endmodule

// ---- dcs_tbp_if.sv ----
/*
  Interface carrying the pool entry table from the pool to the arbiter.
  Assumes both ends share clk_sys.
*/
`timescale 1ns/1ns
interface dcs_tbp_if;
  import dcs_pkg::*;
  logic                  valid [POOL_DEPTH];
  logic                  ready [POOL_DEPTH];
  logic                  row_open [POOL_DEPTH];
  dcs_req_s              req   [POOL_DEPTH];
  logic [POOL_DEPTH-1:0] age_old;
  logic                  issue_col;
  logic                  issue_row;
  logic [TAG_W-1:0]      col_idx;
  logic [TAG_W-1:0]      row_idx;
  modport pool (output valid, ready, row_open, req, age_old,
                input issue_col, issue_row, col_idx, row_idx);
  modport arb  (input valid, ready, row_open, req, age_old,
                output issue_col, issue_row, col_idx, row_idx);
endinterface

// ---- dcs_top.sv ----
/*
  DDR command scheduler: input port, burst split, pool, arbiter, timer,
  sideband refresh/power down, write data timing and PHY command port.
  Assumes configuration bits arrive from a separate register host.
*/
`timescale 1ns/1ns
module dcs_top
  import dcs_pkg::*;
#(
  parameter int BUF_AW = 4
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [CFG_W-1:0]  cfg_wdata,
  input  wire logic              cfg_we,
  output logic [CFG_W-1:0]       cfg_rdata,
  output logic [15:0]            dbg_bus,
  input  wire logic              usr_valid,
  output logic                   usr_ready,
  input  wire logic              usr_is_wr,
  input  wire logic              usr_partial,
  input  wire logic              usr_prio,
  input  wire logic [ADDR_W-1:0] usr_addr,
  input  wire logic [LEN_W-1:0]  usr_len,
  output logic                   usr_stall,
  input  wire logic              usr_wdata_valid,
  output logic [BUF_AW-1:0]      wbuf_fill_ptr,
  output logic [BUF_AW-1:0]      wbuf_drain_ptr,
  output logic [BUF_AW-1:0]      rbuf_fill_ptr,
  output logic [BUF_AW-1:0]      rbuf_drain_ptr,
  output logic                   rd_data_valid,
  input  wire logic              phy_rdata_valid,
  output logic [2:0]             phy_cmd,
  output logic [ADDR_W-1:0]      phy_addr,
  output logic                   phy_wdata_valid,
  output logic                   phy_cke
);
  dcs_tbp_if tbp();

  logic [CFG_W-1:0]  cfg;
  logic              pool_full;
  logic              alloc;
  dcs_req_s          alloc_req;
  logic              act_ok;
  logic              side_hold;

  // Config host: every bit writable and read back
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      cfg <= '0;
    else if (ce && cfg_we)
      cfg <= cfg_wdata;
  end
  assign cfg_rdata = cfg;

  // Burst adapter and generator state
  typedef enum logic [1:0] {DCS_G_IDLE, DCS_G_SPLIT, DCS_G_RMW_WR} dcs_gen_e;
  dcs_gen_e         gst;
  logic [ADDR_W-1:0] g_addr;
  logic [LEN_W-1:0]  g_left;
  logic              g_wr;
  logic              g_part;
  logic              g_prio;
  logic [LEN_W-1:0]  max_len;
  logic [1:0]        bl_step;

  assign bl_step = cfg[CFG_LPDDR3_BIT] ? BL_LP3 : BL_DDR3;
  // Strict memory-mapped mode limits accepted bursts
  assign max_len = cfg[CFG_MM_BIT] ? LEN_W'(MM_MAX_BURST) : LEN_W'(MAX_BURST);

  // Streaming takes a beat on valid; adapter mode also waits for full len
  assign usr_ready = (gst == DCS_G_IDLE) && !pool_full &&
                     (!cfg[CFG_MM_BIT] || usr_len != '0);
  assign usr_stall = pool_full;

  always_comb begin
    alloc     = 1'b0;
    alloc_req = '0;
    unique case (gst)
      DCS_G_IDLE: begin
        alloc = 1'b0;
      end
      DCS_G_SPLIT: begin
        alloc          = !pool_full;
        alloc_req.addr = g_addr;
        alloc_req.prio = g_prio;
        // Partial write reads first
        alloc_req.is_wr = g_wr && !g_part;
        alloc_req.rmw   = g_part;
      end
      DCS_G_RMW_WR: begin
        alloc           = !pool_full;
        alloc_req.addr  = g_addr;
        alloc_req.prio  = g_prio;
        alloc_req.is_wr = 1'b1;
        alloc_req.rmw   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      gst    <= DCS_G_IDLE;
      g_addr <= '0;
      g_left <= '0;
      g_wr   <= 1'b0;
      g_part <= 1'b0;
      g_prio <= 1'b0;
    end else if (ce) begin
      unique case (gst)
        DCS_G_IDLE: begin
          if (usr_valid && usr_ready && usr_len <= max_len) begin
            gst    <= DCS_G_SPLIT;
            g_addr <= usr_addr;
            g_left <= (usr_len == '0) ? LEN_W'(1) : usr_len;
            g_wr   <= usr_is_wr;
            g_part <= usr_is_wr && usr_partial;
            g_prio <= usr_prio;
          end
        end
        DCS_G_SPLIT: begin
          if (!pool_full) begin
            if (g_part) begin
              gst <= DCS_G_RMW_WR;
            end else if (g_left <= LEN_W'(bl_step)) begin
              gst <= DCS_G_IDLE;
            end else begin
              g_left <= g_left - LEN_W'(bl_step);
              g_addr <= g_addr + ADDR_W'(bl_step);
            end
          end
        end
        DCS_G_RMW_WR: begin
          if (!pool_full) begin
            if (g_left <= LEN_W'(bl_step)) begin
              gst <= DCS_G_IDLE;
            end else begin
              gst    <= DCS_G_SPLIT;
              g_left <= g_left - LEN_W'(bl_step);
              g_addr <= g_addr + ADDR_W'(bl_step);
            end
          end
        end
      endcase
    end
  end

  dcs_pool u_pool (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .ce        (ce),
    .alloc     (alloc),
    .alloc_req (alloc_req),
    .full      (pool_full),
    .tbp       (tbp)
  );

  dcs_arb u_arb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .act_ok  (act_ok),
    .hold    (side_hold),
    .quasi   (cfg[CFG_QUASI_BIT]),
    .tbp     (tbp)
  );

  // Global timer: activate history shift and spacing counter
  logic [7:0] rrd_cnt;
  logic [7:0] faw_age [ACT_WINDOW_COUNT];
  logic       faw_busy;

  assign faw_busy = faw_age[ACT_WINDOW_COUNT-1] != 8'h00;
  assign act_ok   = (rrd_cnt == 8'h00) && !faw_busy;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rrd_cnt <= 8'h00;
      for (int i = 0; i < ACT_WINDOW_COUNT; i++)
        faw_age[i] <= 8'h00;
    end else if (ce) begin
      if (tbp.issue_row) begin
        rrd_cnt <= 8'(RRD_CYC - 1);
        faw_age[0] <= 8'(FAW_CYC - 1);
        for (int i = 1; i < ACT_WINDOW_COUNT; i++)
          faw_age[i] <= (faw_age[i-1] > 8'h01) ? faw_age[i-1] - 8'h01 : 8'h00;
      end else begin
        if (rrd_cnt != 8'h00)
          rrd_cnt <= rrd_cnt - 8'h01;
        for (int i = 0; i < ACT_WINDOW_COUNT; i++)
          if (faw_age[i] != 8'h00)
            faw_age[i] <= faw_age[i] - 8'h01;
      end
    end
  end

  // Sideband: refresh interval and idle power down
  typedef enum logic [1:0] {DCS_S_RUN, DCS_S_REF, DCS_S_PD} dcs_side_e;
  dcs_side_e  sst;
  logic [7:0] ref_cnt;
  logic [7:0] idle_cnt;
  logic       pool_empty;
  logic       side_ref;
  logic       side_pde;
  logic       side_pdx;

  always_comb begin
    pool_empty = 1'b1;
    for (int i = 0; i < POOL_DEPTH; i++)
      if (tbp.valid[i])
        pool_empty = 1'b0;
  end

  // Refresh waits for an empty pool; issue goes on meanwhile so it can empty
  assign side_ref  = (sst == DCS_S_RUN) && ref_cnt == 8'h00 && pool_empty;
  assign side_pde  = (sst == DCS_S_RUN) && !side_ref && cfg[CFG_PD_EN_BIT] &&
                     idle_cnt == 8'(IDLE_PD_CYC) && !usr_valid;
  assign side_pdx  = (sst == DCS_S_PD) && (usr_valid || ref_cnt == 8'h00);
  assign side_hold = (sst != DCS_S_RUN);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sst      <= DCS_S_RUN;
      ref_cnt  <= 8'(REFRESH_CYC);
      idle_cnt <= 8'h00;
    end else if (ce) begin
      if (side_ref)
        ref_cnt <= 8'(REFRESH_CYC);
      else if (ref_cnt != 8'h00)
        ref_cnt <= ref_cnt - 8'h01;
      if (!pool_empty || usr_valid || sst != DCS_S_RUN)
        idle_cnt <= 8'h00;
      else if (idle_cnt != 8'(IDLE_PD_CYC))
        idle_cnt <= idle_cnt + 8'h01;
      unique case (sst)
        DCS_S_RUN: begin
          if (side_ref)
            sst <= DCS_S_REF;
          else if (side_pde)
            sst <= DCS_S_PD;
        end
        DCS_S_REF: sst <= DCS_S_RUN;
        DCS_S_PD:  if (side_pdx) sst <= DCS_S_RUN;
      endcase
    end
  end

  // PHY-side command port, registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      phy_cmd  <= 3'(DCS_CMD_NOP);
      phy_addr <= '0;
      phy_cke  <= 1'b1;
    end else if (ce) begin
      phy_cke <= !(side_pde || (sst == DCS_S_PD && !side_pdx));
      if (side_ref) begin
        phy_cmd <= 3'(DCS_CMD_REF);
      end else if (side_pde) begin
        phy_cmd <= 3'(DCS_CMD_PDE);
      end else if (side_pdx) begin
        phy_cmd <= 3'(DCS_CMD_PDX);
      end else if (tbp.issue_col) begin
        phy_cmd  <= tbp.req[tbp.col_idx].is_wr ? 3'(DCS_CMD_WR) : 3'(DCS_CMD_RD);
        phy_addr <= tbp.req[tbp.col_idx].addr;
      end else if (tbp.issue_row) begin
        phy_cmd  <= 3'(DCS_CMD_ACT);
        phy_addr <= tbp.req[tbp.row_idx].addr;
      end else begin
        phy_cmd <= 3'(DCS_CMD_NOP);
      end
    end
  end

  // Data buffer pointers and write latency pipe
  logic                     wr_issue;
  logic                     rd_issue;
  logic [WRITE_LAT_CYC-1:0] wl_pipe;

  assign wr_issue = tbp.issue_col && tbp.req[tbp.col_idx].is_wr;
  assign rd_issue = tbp.issue_col && !tbp.req[tbp.col_idx].is_wr;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wbuf_fill_ptr  <= '0;
      wbuf_drain_ptr <= '0;
      rbuf_fill_ptr  <= '0;
      rbuf_drain_ptr <= '0;
      rd_data_valid  <= 1'b0;
    end else if (ce) begin
      if (usr_wdata_valid)
        wbuf_fill_ptr <= wbuf_fill_ptr + BUF_AW'(1);
      if (wl_pipe[WRITE_LAT_CYC-1])
        wbuf_drain_ptr <= wbuf_drain_ptr + BUF_AW'(1);
      if (phy_rdata_valid)
        rbuf_fill_ptr <= rbuf_fill_ptr + BUF_AW'(1);
      rd_data_valid <= rbuf_fill_ptr != rbuf_drain_ptr;
      if (rbuf_fill_ptr != rbuf_drain_ptr)
        rbuf_drain_ptr <= rbuf_drain_ptr + BUF_AW'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wl_pipe         <= '0;
      phy_wdata_valid <= 1'b0;
    end else if (ce) begin
      wl_pipe         <= {wl_pipe[WRITE_LAT_CYC-2:0], wr_issue};
      phy_wdata_valid <= wl_pipe[WRITE_LAT_CYC-1];
    end
  end

  // Debug bus, registered status snapshot on its own port
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      dbg_bus <= '0;
    else if (ce)
      dbg_bus <= {pool_full, pool_empty, act_ok, rd_issue, 2'(gst), 2'(sst),
                  rrd_cnt};
  end
endmodule

// ---- dcs_user_model.sv ----
/*
  User core logic model driving the scheduler's command port.
  Assumes the bench raises start for one cycle per burst.
*/
`timescale 1ns/1ns
module dcs_user_model
  import dcs_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire dcs_req_s         req,
  input  wire logic [LEN_W-1:0] len,
  input  wire logic             usr_ready,
  output logic                  usr_valid,
  output dcs_req_s              usr_req,
  output logic [LEN_W-1:0]      usr_len,
  output logic                  done
);
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      usr_valid <= 1'b0;
      done <= 1'b0;
      usr_req <= '0;
      usr_len <= '0;
    end else begin
      done <= #1 usr_valid && usr_ready;
      if (usr_valid && usr_ready) begin
        usr_valid <= #1 1'b0;
        // Released fields flip so a stale value never passes as held
        usr_req <= #1 ~usr_req;
        usr_len <= #1 ~usr_len;
      end else if (start && !usr_valid) begin
        usr_valid <= #1 1'b1;
        usr_req <= #1 req;
        usr_len <= #1 len;
      end
    end
  end
endmodule

// ---- test_ddr_command_scheduler.sv ----
/*
  Self-checking bench of the scheduler top with a user-side model.
  Assumes a free-running 20 MHz clock and no register bus.
*/
`timescale 1ns/1ns
module test_ddr_command_scheduler;
  import dcs_pkg::*;
  logic clk_sys = 0, rst = 1, ce = 1, cfg_we = 0, wdv = 0, rdv = 0, m_start = 0;
  logic [CFG_W-1:0] cfg_wdata = '0, cfg_rdata;
  logic [15:0] dbg_bus;
  logic u_valid, usr_ready, usr_stall, rd_data_valid, phy_wdata_valid, phy_cke, m_done;
  dcs_req_s m_req = '0, u_req;
  logic [LEN_W-1:0] m_len = '0, u_len;
  logic [3:0] wf, wd, rf, rd;
  logic [2:0] phy_cmd;
  logic [ADDR_W-1:0] phy_addr, last_rd;
  logic [CFG_W-1:0] modes [4] = '{8'h00, 8'h04, 8'h06, 8'h0e};
  int err_count = 0, total_checks = 0, seed = 73458, cyc = 0;
  int n_rd = 0, n_wr = 0, n_ref = 0, n_rdv = 0, exp_rd = 0, exp_wr = 0, k, r0;

  always #25 clk_sys = ~clk_sys;

  dcs_user_model i_user (.clk_sys(clk_sys), .rst(rst), .start(m_start), .req(m_req),
    .len(m_len), .usr_ready(usr_ready), .usr_valid(u_valid), .usr_req(u_req),
    .usr_len(u_len), .done(m_done));

  dcs_top i_dut (.clk_sys(clk_sys), .rst(rst), .ce(ce), .cfg_wdata(cfg_wdata), .cfg_we(cfg_we),
    .cfg_rdata(cfg_rdata), .dbg_bus(dbg_bus), .usr_valid(u_valid), .usr_ready(usr_ready),
    .usr_is_wr(u_req.is_wr), .usr_partial(u_req.rmw), .usr_prio(u_req.prio),
    .usr_addr(u_req.addr), .usr_len(u_len), .usr_stall(usr_stall), .usr_wdata_valid(wdv),
    .wbuf_fill_ptr(wf), .wbuf_drain_ptr(wd), .rbuf_fill_ptr(rf), .rbuf_drain_ptr(rd),
    .rd_data_valid(rd_data_valid), .phy_rdata_valid(rdv), .phy_cmd(phy_cmd),
    .phy_addr(phy_addr), .phy_wdata_valid(phy_wdata_valid), .phy_cke(phy_cke));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask

  function automatic int pieces(input int len);
    return (len + 1) / 2;
  endfunction

  // Expected command counts follow from the split into two-beat steps
  task automatic send(input logic w, p, input logic [LEN_W-1:0] l, input logic drop);
    m_req = '{is_wr: w, rmw: w & p, prio: $random(seed), addr: $random(seed)};
    m_len = l;
    m_start = 1;
    step();
    m_start = 0;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (!m_done && k < 2000);
    #1;
    chk(k < 2000, 1, "command not taken");
    if (!drop && (!w || p)) exp_rd += pieces(l);
    if (!drop && w) exp_wr += pieces(l);
  endtask

  task automatic drain();
    for (k = 0; k < 3000 && (n_rd != exp_rd || n_wr != exp_wr); k++) step();
    chk(n_rd, exp_rd, "read commands");
    chk(n_wr, exp_wr, "write commands");
  endtask

  task automatic cfg(input logic [CFG_W-1:0] v);
    cfg_wdata = v;
    cfg_we = 1;
    step();
    cfg_we = 0;
    chk(cfg_rdata, v, "config readback");
    step();
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (!rst && ce) begin
      n_rd += (phy_cmd === DCS_CMD_RD);
      if (phy_cmd === DCS_CMD_RD) last_rd = phy_addr;
      n_wr += (phy_cmd === DCS_CMD_WR);
      n_ref += (phy_cmd === DCS_CMD_REF);
      n_rdv += (rd_data_valid === 1'b1);
      if (phy_cmd === DCS_CMD_RD || phy_cmd === DCS_CMD_WR) chk(phy_cke, 1, "cmd while asleep");
    end
    if (cyc == 40000) begin
      err_count++;
      $display("BAD %0t run did not finish", $time);
      final_report();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    #1 rst = 0;
    chk({phy_cmd, phy_cke, usr_stall, usr_ready}, 6'h05, "reset state");
    chk({wf, wd, rf, rd}, 0, "reset pointers");
    step();
    chk(dbg_bus[15:14], 2'b01, "debug empty flag");
    $display("test reset done");
    // Five beats each way count; three more with ce low must not
    repeat (5) begin wdv = 1; rdv = 1; step(); end
    ce = 0;
    repeat (3) step();
    wdv = 0;
    rdv = 0;
    ce = 1;
    for (k = 0; k < 50 && n_rdv < 5; k++) step();
    chk({wf, rf, rd}, 12'h555, "buffer pointers");
    chk(n_rdv, 5, "read beats to user");
    $display("test pointers done");
    for (int i = 0; i < 4; i++) cfg(8'($random(seed)));
    foreach (modes[m]) begin
      cfg(modes[m]);
      send(1, 1, 7'd127, 0);
      send(1, 0, 7'd1, 0);
      for (int i = 0; i < 6; i++)
        send($random(seed), $random(seed), 7'(($random(seed) & 15) + 1), 0);
      drain();
    end
    $display("test traffic done");
    cfg(8'h01);
    send(0, 0, 7'd64, 0);
    send(0, 0, 7'd65, 1);
    drain();
    $display("test strict bursts done");
    r0 = n_ref;
    for (k = 0; k < 400 && n_ref == r0; k++) step();
    chk(n_ref > r0, 1, "refresh issued");
    cfg(8'h10);
    for (k = 0; k < 300 && phy_cke; k++) step();
    chk(phy_cke, 0, "power down");
    send(0, 0, 7'd2, 0);
    drain();
    chk(last_rd, m_req.addr, "read address");
    chk(wd, exp_wr & 15, "write drain pointer");
    $display("test sideband done");
    final_report();
  end
endmodule
